// File: rtl/ocdiv_pkg.sv
// constants for the three-channel output clock divider block
// assumes a single 125 MHz clock and an APB register slave with 32-bit data
package ocdiv_pkg;

    localparam int NUM_CH = 3;
    localparam int NUM_SLOTS = 10;
    localparam int ADDR_W = 13;

    // register indices as printed; byte address is four times the index
    localparam logic [10:0] IDX_DIV1_CYCLE_COUNTS = 11'h093;
    localparam logic [10:0] IDX_DIV1_START_PHASE = 11'h094;
    localparam logic [10:0] IDX_CH1_POWER_DUTY = 11'h095;
    localparam logic [10:0] IDX_DIV2_CYCLE_COUNTS = 11'h096;
    localparam logic [10:0] IDX_DIV2_BYPASS_CTRL = 11'h097;
    localparam logic [10:0] IDX_DIV2_SYNC_FORCE_PHASE = 11'h197;
    localparam logic [10:0] IDX_CH2_POWER_DUTY = 11'h198;
    localparam logic [10:0] IDX_DIV3_CYCLE_COUNTS = 11'h199;
    localparam logic [10:0] IDX_DIV3_CTRL = 11'h19a;
    localparam logic [10:0] IDX_CH3_POWER_DUTY = 11'h19b;

    // storage slots
    localparam logic [3:0] SLOT_DIV1_CYC = 4'h0;
    localparam logic [3:0] SLOT_DIV1_CTL = 4'h1;
    localparam logic [3:0] SLOT_CH1_PWR = 4'h2;
    localparam logic [3:0] SLOT_DIV2_CYC = 4'h3;
    localparam logic [3:0] SLOT_DIV2_BYP = 4'h4;
    localparam logic [3:0] SLOT_DIV2_CTL = 4'h5;
    localparam logic [3:0] SLOT_CH2_PWR = 4'h6;
    localparam logic [3:0] SLOT_DIV3_CYC = 4'h7;
    localparam logic [3:0] SLOT_DIV3_CTL = 4'h8;
    localparam logic [3:0] SLOT_CH3_PWR = 4'h9;

    // per channel slot map
    localparam logic [3:0] CYC_SLOT [NUM_CH] = '{SLOT_DIV1_CYC, SLOT_DIV2_CYC, SLOT_DIV3_CYC};
    localparam logic [3:0] CTL_SLOT [NUM_CH] = '{SLOT_DIV1_CTL, SLOT_DIV2_CTL, SLOT_DIV3_CTL};
    localparam logic [3:0] BYP_SLOT [NUM_CH] = '{SLOT_DIV1_CTL, SLOT_DIV2_BYP, SLOT_DIV3_CTL};
    localparam logic [3:0] PWR_SLOT [NUM_CH] = '{SLOT_CH1_PWR, SLOT_CH2_PWR, SLOT_CH3_PWR};

    // reset values per slot
    localparam logic [7:0] RST_VAL [NUM_SLOTS] = '{
        8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };
    // writable bits per slot; others read zero
    localparam logic [7:0] WR_MASK [NUM_SLOTS] = '{
        8'hff, 8'hff, 8'h05, 8'hff, 8'h80, 8'h7f, 8'h05, 8'hff, 8'hff, 8'h05
    };

    // field positions
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;
    localparam int BIT_BYPASS = 7;
    localparam int BIT_IGNORE_SYNC = 6;
    localparam int BIT_FORCE_HIGH = 5;
    localparam int BIT_START_HIGH = 4;
    localparam int PHASE_MSB = 3;
    localparam int PHASE_LSB = 0;
    localparam int BIT_POWER_DOWN = 2;
    localparam int BIT_CORR_DISABLE = 0;

    typedef enum logic [1:0] {
        S_DELAY,
        S_RUN
    } ocdiv_state_t;

endpackage

// File: rtl/ocdiv_out_stage.sv
// output stage of one channel: three outputs, enables, correction flag
// assumes divided level and controls come from flops on the same clock
`timescale 1ns/1ns
module ocdiv_out_stage (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // from divider
    input wire logic level,
    input wire logic power_down,
    input wire logic bypass,
    input wire logic corr_disable,
    // to pins
    output logic [2:0] out_clk,
    output logic [2:0] out_oe_n,
    output logic duty_cycle_correction_on
);

    typedef struct packed {
        logic [2:0] clk;
        logic [2:0] oe_n;
        logic corr;
    } ocdiv_stage_t;

    ocdiv_stage_t q;
    ocdiv_stage_t next_q;

    always_comb begin
        next_q = q;
        // powered-down outputs stop driving and hold low
        next_q.clk = power_down ? 3'h0 : {3{level}};
        next_q.oe_n = {3{power_down}};
        // correction stage sits behind the divider, so it is idle in bypass
        next_q.corr = !corr_disable && !bypass && !power_down;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '{clk: 3'h0, oe_n: 3'h0, corr: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign out_clk = q.clk;
    assign out_oe_n = q.oe_n;
    assign duty_cycle_correction_on = q.corr;

endmodule

// File: rtl/ocdiv_top.sv
// three-channel output clock divider with APB register slave
// assumes chip_sync arrives asynchronously; APB master on mclk
`timescale 1ns/1ns
module ocdiv_top #(
    parameter int ADDR_W = ocdiv_pkg::ADDR_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // chip-level sync, asynchronous
    input wire logic chip_sync,
    // channel outputs, three clocks and three enables per channel, one correction flag per channel
    output logic [8:0] out_clk,
    output logic [8:0] out_oe_n,
    output logic [2:0] duty_cycle_correction_on
);

    localparam int NCH = ocdiv_pkg::NUM_CH;

    typedef struct packed {
        logic [ocdiv_pkg::NUM_SLOTS-1:0][7:0] regs;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sync_meta;
        logic sync_sync;
        ocdiv_pkg::ocdiv_state_t [NCH-1:0] st;
        logic [NCH-1:0][3:0] cnt;
        logic [NCH-1:0] level;
        logic [NCH-1:0] bypass;
        logic [NCH-1:0] power_down;
        logic [NCH-1:0] corr_disable;
    } ocdiv_top_t;

    ocdiv_top_t q;
    ocdiv_top_t next_q;

    // returns {valid, slot}; misaligned or unmapped addresses are invalid
    function automatic logic [4:0] ocdiv_decode(input logic [ADDR_W-1:0] addr);
        logic [4:0] res;
        res = 5'h00;
        if (addr[1:0] == 2'h0) begin
            case (addr[12:2])
                ocdiv_pkg::IDX_DIV1_CYCLE_COUNTS: res = {1'b1, ocdiv_pkg::SLOT_DIV1_CYC};
                ocdiv_pkg::IDX_DIV1_START_PHASE: res = {1'b1, ocdiv_pkg::SLOT_DIV1_CTL};
                ocdiv_pkg::IDX_CH1_POWER_DUTY: res = {1'b1, ocdiv_pkg::SLOT_CH1_PWR};
                ocdiv_pkg::IDX_DIV2_CYCLE_COUNTS: res = {1'b1, ocdiv_pkg::SLOT_DIV2_CYC};
                ocdiv_pkg::IDX_DIV2_BYPASS_CTRL: res = {1'b1, ocdiv_pkg::SLOT_DIV2_BYP};
                ocdiv_pkg::IDX_DIV2_SYNC_FORCE_PHASE: res = {1'b1, ocdiv_pkg::SLOT_DIV2_CTL};
                ocdiv_pkg::IDX_CH2_POWER_DUTY: res = {1'b1, ocdiv_pkg::SLOT_CH2_PWR};
                ocdiv_pkg::IDX_DIV3_CYCLE_COUNTS: res = {1'b1, ocdiv_pkg::SLOT_DIV3_CYC};
                ocdiv_pkg::IDX_DIV3_CTRL: res = {1'b1, ocdiv_pkg::SLOT_DIV3_CTL};
                ocdiv_pkg::IDX_CH3_POWER_DUTY: res = {1'b1, ocdiv_pkg::SLOT_CH3_PWR};
                default: res = 5'h00;
            endcase
        end
        return res;
    endfunction

    function automatic ocdiv_top_t ocdiv_reset_value();
        ocdiv_top_t r;
        r = '0;
        for (int s = 0; s < ocdiv_pkg::NUM_SLOTS; s++) begin
            r.regs[s] = ocdiv_pkg::RST_VAL[s];
        end
        for (int c = 0; c < NCH; c++) begin
            r.st[c] = ocdiv_pkg::S_DELAY;
        end
        return r;
    endfunction

    always_comb begin
        logic [4:0] dec;
        logic [7:0] cyc;
        logic [7:0] ctl;
        logic [7:0] pwr;
        logic byp;
        logic ign;
        logic start_lvl;
        logic [3:0] len;
        logic [3:0] phase;
        dec = 5'h00;
        cyc = 8'h00;
        ctl = 8'h00;
        pwr = 8'h00;
        byp = 1'b0;
        ign = 1'b0;
        start_lvl = 1'b0;
        len = 4'h0;
        phase = 4'h0;
        next_q = q;

        // sync pin, two flops before use
        next_q.sync_meta = chip_sync;
        next_q.sync_sync = q.sync_meta;

        // apb: one wait state, answer registered
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            dec = ocdiv_decode(paddr);
            next_q.pready = 1'b1;
            if (!dec[4]) begin
                next_q.pslverr = 1'b1;
                next_q.prdata = 32'h0000_0000;
            end else if (!pwrite) begin
                next_q.prdata = {24'h00_0000, q.regs[dec[3:0]]};
            end
        end
        if (psel && penable && q.pready && pwrite && pstrb[0]) begin
            dec = ocdiv_decode(paddr);
            if (dec[4]) begin
                next_q.regs[dec[3:0]] = pwdata[7:0] & ocdiv_pkg::WR_MASK[dec[3:0]];
            end
        end

        // divider engines, one per channel
        for (int c = 0; c < NCH; c++) begin
            cyc = q.regs[ocdiv_pkg::CYC_SLOT[c]];
            ctl = q.regs[ocdiv_pkg::CTL_SLOT[c]];
            pwr = q.regs[ocdiv_pkg::PWR_SLOT[c]];
            byp = q.regs[ocdiv_pkg::BYP_SLOT[c]][ocdiv_pkg::BIT_BYPASS];
            ign = ctl[ocdiv_pkg::BIT_IGNORE_SYNC];
            start_lvl = ctl[ocdiv_pkg::BIT_START_HIGH];
            phase = ctl[ocdiv_pkg::PHASE_MSB:ocdiv_pkg::PHASE_LSB];
            len = q.level[c] ? cyc[ocdiv_pkg::HIGH_MSB:ocdiv_pkg::HIGH_LSB]
                             : cyc[ocdiv_pkg::LOW_MSB:ocdiv_pkg::LOW_LSB];
            next_q.bypass[c] = byp;
            next_q.power_down[c] = pwr[ocdiv_pkg::BIT_POWER_DOWN];
            next_q.corr_disable[c] = pwr[ocdiv_pkg::BIT_CORR_DISABLE];

            if (byp) begin
                // flop-rate stand-in for the raw input clock; restarts clean on exit
                next_q.level[c] = !q.level[c];
                next_q.st[c] = ocdiv_pkg::S_DELAY;
                next_q.cnt[c] = 4'h0;
            end else if (q.sync_sync && !ign) begin
                // held at start level while sync stands
                next_q.level[c] = start_lvl;
                next_q.st[c] = ocdiv_pkg::S_DELAY;
                next_q.cnt[c] = 4'h0;
            end else if (q.sync_sync && ign) begin
                // counter frozen so the clock resumes where it stopped
                next_q.level[c] = ctl[ocdiv_pkg::BIT_FORCE_HIGH];
            end else begin
                case (q.st[c])
                    ocdiv_pkg::S_DELAY: begin
                        next_q.level[c] = start_lvl;
                        if (q.cnt[c] == phase) begin
                            next_q.st[c] = ocdiv_pkg::S_RUN;
                            next_q.cnt[c] = 4'h0;
                        end else begin
                            next_q.cnt[c] = q.cnt[c] + 4'h1;
                        end
                    end
                    ocdiv_pkg::S_RUN: begin
                        if (q.cnt[c] >= len) begin
                            next_q.level[c] = !q.level[c];
                            next_q.cnt[c] = 4'h0;
                        end else begin
                            next_q.cnt[c] = q.cnt[c] + 4'h1;
                        end
                    end
                    default: begin
                        next_q.st[c] = ocdiv_pkg::S_DELAY;
                        next_q.cnt[c] = 4'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= ocdiv_reset_value();
        end else begin
            q <= next_q;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        ocdiv_out_stage u_stage (
            .mclk(mclk),
            .reset(reset),
            .level(q.level[g]),
            .power_down(q.power_down[g]),
            .bypass(q.bypass[g]),
            .corr_disable(q.corr_disable[g]),
            .out_clk(out_clk[3*g+2:3*g]),
            .out_oe_n(out_oe_n[3*g+2:3*g]),
            .duty_cycle_correction_on(duty_cycle_correction_on[g])
        );
    end

endmodule

// File: testbench/ocdiv_properties.sv
// port checker for the three-channel divider block
// assumes one clock mclk and a synchronous active-high reset
`timescale 1ns/1ns
module ocdiv_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // channel pins
    input wire logic [8:0] out_clk,
    input wire logic [8:0] out_oe_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_time_a: assert property (psel && $rose(penable) |=> pready) else $error("pready not in second access cycle");
    ready_cause_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("error read data");
    rdata_upper_a: assert property (prdata[31:8] == 24'h00_0000) else $error("read data upper bits set");
    rdata_hold_a: assert property ($changed(prdata) |-> pready) else $error("read data moved");
    clk_group_a: assert property (out_clk == {{3{out_clk[6]}}, {3{out_clk[3]}}, {3{out_clk[0]}}})
        else $error("channel outputs differ");
    oe_group_a: assert property (out_oe_n == {{3{out_oe_n[6]}}, {3{out_oe_n[3]}}, {3{out_oe_n[0]}}})
        else $error("channel enables differ");
    pwrdn_quiet_a: assert property ((out_oe_n & out_clk) == 9'h000) else $error("released pin high");
endmodule
bind ocdiv_top ocdiv_checker ocdiv_checker_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_clk(out_clk), .out_oe_n(out_oe_n));

// File: testbench/ocdiv_sink.sv
// downstream receiver: measures high and low run lengths of one output
// assumes outputs change only just after mclk rising edges
`timescale 1ns/1ns
module ocdiv_sink (
    // clock
    input wire logic mclk,
    // pin
    input wire logic clk_in,
    input wire logic oe_n_in,
    // measured runs
    output int high_len,
    output int low_len
);
    int run = 0;
    logic last = 1'b0;
    // a released pin carries no trusted level, so runs restart
    always @(posedge mclk) begin
        if (oe_n_in !== 1'b0) begin
            run <= 0;
        end else if (clk_in !== last) begin
            if (last === 1'b1) begin
                high_len <= run;
            end else begin
                low_len <= run;
            end
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= clk_in;
    end
endmodule

// File: testbench/ocdiv_top_tb.sv
// self-checking bench for the divider block
// assumes the APB timing and register map of the design
`timescale 1ns/1ns
module ocdiv_top_tb;
    localparam logic [10:0] IX [10] = '{11'h093, 11'h094, 11'h095, 11'h096, 11'h097,
        11'h197, 11'h198, 11'h199, 11'h19a, 11'h19b};
    localparam logic [7:0] RV [10] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MK [10] = '{8'hff, 8'hff, 8'h05, 8'hff, 8'h80, 8'h7f, 8'h05, 8'hff, 8'hff, 8'h05};
    logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, chip_sync = 0, pready, pslverr, er;
    logic [12:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0;
    logic [8:0] out_clk, out_oe_n;
    logic [2:0] corr_on;
    int high_len [3];
    int low_len [3];
    int err_total = 0, cmp_count = 0, n0, n3, nf;
    always #4 mclk = ~mclk;
    ocdiv_top ocdiv_top_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_sync(chip_sync), .out_clk(out_clk), .out_oe_n(out_oe_n), .duty_cycle_correction_on(corr_on));
    for (genvar c = 0; c < 3; c++) begin : g_sink
        ocdiv_sink ocdiv_sink_inst (.mclk(mclk), .clk_in(out_clk[3*c]), .oe_n_in(out_oe_n[3*c]),
            .high_len(high_len[c]), .low_len(low_len[c]));
    end
    // wide enough for paired run lengths and the error flag with read data
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [7:0] d, input logic [3:0] st);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 64'd2, "answer latency");
        @(posedge mclk);
    endtask
    task automatic wr(input logic [10:0] i, input logic [7:0] d);
        apb(1'b1, {i, 2'b00}, d, 4'h1);
    endtask
    task automatic rdchk(input logic [10:0] i, input logic [7:0] e, input string m);
        apb(1'b0, {i, 2'b00}, 8'h00, 4'h0);
        chk(rd, {24'h00_0000, e}, m);
    endtask
    task automatic hold(input logic v, input string m);
        repeat (4) @(posedge mclk);
        repeat (8) begin
            @(posedge mclk);
            chk(out_clk[3], v, m);
        end
    endtask
    task automatic lead(input logic [7:0] ctl, output int n);
        wr(11'h197, ctl);
        chip_sync <= 1'b1;
        repeat (8) @(posedge mclk);
        chip_sync <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (out_clk[3] !== 1'b1 && n < 60);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 10; i++) rdchk(IX[i], RV[i], "reset value");
        apb(1'b1, {IX[3], 2'b00}, 8'hff, 4'h0);
        rdchk(IX[3], 8'h11, "strobe off");
        for (int i = 0; i < 10; i++) begin
            wr(IX[i], 8'hff);
            rdchk(IX[i], MK[i], "mask");
            wr(IX[i], RV[i]);
        end
        apb(1'b0, 13'h0780, 8'h00, 4'h0);
        chk({er, rd}, 33'h1_0000_0000, "unmapped");
        apb(1'b0, 13'h024d, 8'h00, 4'h0);
        chk(er, 1'b1, "misaligned");
        $display("test regs done");
    endtask
    task automatic t_div;
        repeat (40) @(posedge mclk);
        chk({low_len[0], high_len[0]}, {32'd4, 32'd4}, "div1 default");
        chk({low_len[1], high_len[1]}, {32'd2, 32'd2}, "div2 default");
        chk({low_len[2], high_len[2]}, {32'd1, 32'd1}, "div3 default");
        chk(corr_on, 3'h7, "correction on");
        wr(11'h096, 8'h24);
        repeat (40) @(posedge mclk);
        chk({low_len[1], high_len[1]}, {32'd3, 32'd5}, "div2 counts");
        $display("test div done");
    endtask
    task automatic t_force;
        chip_sync <= 1'b1;
        wr(11'h197, 8'h60);
        hold(1'b1, "forced high");
        wr(11'h197, 8'h40);
        hold(1'b0, "forced low");
        wr(11'h197, 8'h20);
        hold(1'b0, "force needs ignore");
        wr(11'h197, 8'h10);
        hold(1'b1, "sync holds start high");
        wr(11'h197, 8'h60);
        wr(11'h097, 8'h80);
        repeat (40) @(posedge mclk);
        chk({low_len[1], high_len[1]}, {32'd1, 32'd1}, "bypass");
        chk(corr_on[1], 1'b0, "bypass correction");
        wr(11'h097, 8'h00);
        chip_sync <= 1'b0;
        $display("test force done");
    endtask
    task automatic t_phase;
        lead(8'h00, n0);
        lead(8'h03, n3);
        lead(8'h0f, nf);
        chk(n3 - n0, 32'd3, "phase 3");
        chk(nf - n0, 32'd15, "phase 15");
        wr(11'h197, 8'h00);
        $display("test phase done");
    endtask
    task automatic t_power;
        wr(11'h198, 8'h04);
        repeat (3) @(posedge mclk);
        chk({out_oe_n, out_clk[5:3], corr_on}, {9'h038, 3'h0, 3'h5}, "power down");
        wr(11'h198, 8'h01);
        repeat (3) @(posedge mclk);
        chk({out_oe_n, corr_on}, {9'h000, 3'h5}, "correction off");
        wr(11'h198, 8'h00);
        $display("test power done");
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_div;
        t_force;
        t_phase;
        t_power;
        test_done;
    end
    initial begin
        #100000;
        err_total++;
        test_done;
    end
endmodule
